// >>> mexc_pkg.sv
// Purpose: Shared constants for the memory exception reporting block
// Assumes: Status bit n of the word maps to vector index 31-n
// Notes:   Reserved bits of the status word read as zero
package mexc_pkg;

  // Bit 0 is the most significant bit of the word
  function automatic int unsigned bitpos(input int unsigned n);
    return 31 - n;
  endfunction : bitpos

  localparam int unsigned B_SEGPROT  = bitpos(14);
  localparam int unsigned B_INV_MEM  = bitpos(17);
  localparam int unsigned B_INV_IO   = bitpos(18);
  localparam int unsigned B_ACC_LOAD = bitpos(19);
  localparam int unsigned B_UE       = bitpos(20);
  localparam int unsigned B_CE       = bitpos(21);
  localparam int unsigned B_RELOAD   = bitpos(22);
  localparam int unsigned B_ROM_WR   = bitpos(24);
  localparam int unsigned B_PT_SPEC  = bitpos(25);
  localparam int unsigned B_EXT_DEV  = bitpos(26);
  localparam int unsigned B_MULTI    = bitpos(27);
  localparam int unsigned B_PG_FAULT = bitpos(28);
  localparam int unsigned B_TLB_SPEC = bitpos(29);
  localparam int unsigned B_PROT     = bitpos(30);
  localparam int unsigned B_DATA     = bitpos(31);

  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  // Implemented bits 14 and 17..31 except 23
  localparam logic [31:0] STATUS_MASK  = 32'h0002_7eff;
  // Real memory addresses use the low 24 bits
  localparam logic [31:0] REAL_MASK    = 32'h00ff_ffff;
  localparam logic [6:0]  SEARCH_LIMIT = 7'h7f;
  localparam logic [6:0]  SEARCH_RESET = 7'h00;

  // Real address: bits 0-7 forced to zero
  function automatic logic [31:0] real_addr(input logic [31:0] a);
    return a & REAL_MASK;
  endfunction : real_addr

endpackage : mexc_pkg

// >>> search_limit.sv
// Purpose: Counts entries compared in one page-table search chain
// Assumes: Start, compare and match strobes come from the search engine
// Notes:   Reports the limit once per chain, only when enabled
`timescale 1ns/1ps
module search_limit (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic start_i,
  input  wire logic compare_i,
  input  wire logic match_i,
  output logic      limit_o
);
  logic [6:0] count_ff;
  logic [6:0] nxt_count;
  logic       limit_ff;
  wire        at_limit = (count_ff == mexc_pkg::SEARCH_LIMIT);
  wire        hit_now  = enable_i & compare_i & ~match_i &
                         (count_ff == mexc_pkg::SEARCH_LIMIT - 7'h01);

  // Saturate so a looping chain never wraps back to zero
  assign nxt_count = start_i ? mexc_pkg::SEARCH_RESET :
                     (compare_i & ~at_limit) ? count_ff + 7'h01 : count_ff;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count_ff <= mexc_pkg::SEARCH_RESET;
      limit_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      limit_ff <= hit_now & ~start_i;
    end
  end

  assign limit_o = limit_ff;
endmodule : search_limit

// >>> mem_exc_report.sv
// Purpose: Records memory exceptions and picks the response for each
// Assumes: Event strobes are one-cycle pulses on mclk_i from the datapath
// Notes:   Address holder storage lives outside; this block steers it
//
// Operation
// - Invalid memory: reply for reads/translated writes, else program check; load address.
// - Invalid I/O flag on reserved I/O location or read of write-only location.
// - Invalid I/O: reply on reads unless diagnostic, program check on writes, load.
// - Access-type flag is 1 for loads, 0 for stores or test-and-set.
// - Uncorrectable ECC: flag, reply for reads/translated writes, machine check; responses suppressed in diagnostic.
// - ECC error loads address, then holds it and latches check bits until read.
// - Correctable ECC flag set unless uncorrectable flag already set or set in the same cycle.
// - Correctable with enable: machine check unless diagnostic, load address.
// - Reload report enabled: set reload flag and reply unless diagnostic.
// - ROM write sets flag, program check, loads address.
// - Long search enabled: flag when 127 entries compared without match.
// - Table, page fault, protection, data errors reply unless diagnostic.
// - Those errors from processor load/store load address and lock holder.
// - External-device flag when those exceptions come from the I/O controller.
// - Multiple flag on further processor virtual exception while holder locked and a virtual flag already set.
// - Page fault flag on no translation, reset during reload, aborted reload.
// - Duplicate TLB match: flag, reply and machine check; load and lock when from processor load/store.
// - Store on duplicate match uses OR of both real page numbers.
// - Protection flag when non-special segment protection denies processor access.
// - Data flag when special segment lock check denies processor access.
// - Flags become visible one cycle after the faulting access; the long-search flag appears two cycles after the 127th compare.
// - Status clears at reset, flags stick, read releases program check.
// - Diagnostic mode suppresses machine checks and non-addressing replies.
`timescale 1ns/1ps
module mem_exc_report (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // Control bits of translation_control_register
  input  wire logic        diag_mode_i,
  input  wire logic        ce_int_en_i,
  input  wire logic        reload_rpt_en_i,
  input  wire logic        long_search_en_i,
  // Access attributes, valid with any event strobe
  input  wire logic [31:0] fault_addr_i,
  input  wire logic        acc_read_i,
  input  wire logic        acc_translated_i,
  input  wire logic        acc_load_i,
  input  wire logic        src_cpu_i,
  input  wire logic        src_cpu_ldst_i,
  input  wire logic        src_io_channel_controller_i,
  // Event strobes
  input  wire logic        ev_inv_mem_i,
  input  wire logic        ev_io_reserved_i,
  input  wire logic        ev_io_rd_wronly_i,
  input  wire logic        ev_io_write_i,
  input  wire logic        ev_ue_i,
  input  wire logic        ev_ce_i,
  input  wire logic        ev_reload_ok_i,
  input  wire logic        ev_rom_wr_i,
  input  wire logic        ev_no_xlate_i,
  input  wire logic        ev_reset_in_reload_i,
  input  wire logic        ev_reload_abort_i,
  input  wire logic        ev_dup_tlb_i,
  input  wire logic        ev_segprot_i,
  input  wire logic        ev_prot_i,
  input  wire logic        ev_data_i,
  // Page-table search progress
  input  wire logic        search_start_i,
  input  wire logic        search_compare_i,
  input  wire logic        search_match_i,
  // Duplicate match page numbers
  input  wire logic [21:0] rpn_a_i,
  input  wire logic [21:0] rpn_b_i,
  // Register access by I/O instructions
  input  wire logic        status_rd_i,
  input  wire logic        status_wr_i,
  input  wire logic [31:0] status_wdata_i,
  input  wire logic        holder_access_i,
  input  wire logic        diag_reg_rd_i,
  output logic [31:0]      status_rdata_o,
  output logic             exc_reply_o,
  output logic             machine_check_o,
  output logic             pgm_check_n_o,
  output logic             holder_load_o,
  output logic [31:0]      holder_addr_o,
  output logic             holder_locked_o,
  output logic             ecc_hold_o,
  output logic             ecc_bits_latch_o,
  output logic [21:0]      store_rpn_o
);
  logic [31:0] status_ff;
  logic [31:0] rdata_ff;
  logic        reply_ff;
  logic        mchk_ff;
  logic        pgm_n_ff;
  logic        load_ff;
  logic [31:0] addr_ff;
  logic        lock_ff;
  logic        hold_ff;
  logic        latch_ff;
  logic [21:0] rpn_ff;
  logic        long_stop;
  logic [31:0] set_bits;
  logic [31:0] nxt_status;

  search_limit u_search (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .enable_i  (long_search_en_i),
    .start_i   (search_start_i),
    .compare_i (search_compare_i),
    .match_i   (search_match_i),
    .limit_o   (long_stop)
  );

  // Event classification
  wire inv_io    = ev_io_reserved_i | ev_io_rd_wronly_i;
  wire pg_fault  = ev_no_xlate_i | ev_reset_in_reload_i |
                   ev_reload_abort_i;
  wire virt_ev   = ev_segprot_i | long_stop | pg_fault | ev_prot_i |
                   ev_data_i;
  wire virt_cpu  = (virt_ev | ev_dup_tlb_i) & src_cpu_ldst_i;
  wire ce_report = ev_ce_i & (ce_int_en_i | diag_mode_i);
  wire real_ev   = ev_inv_mem_i | inv_io | ev_ue_i | ev_rom_wr_i |
                   (ev_ce_i & ce_int_en_i);
  wire virt_mask = |(status_ff & {32{1'b1}} &
                   ((32'h1 << mexc_pkg::B_SEGPROT) |
                    (32'h1 << mexc_pkg::B_PT_SPEC) |
                    (32'h1 << mexc_pkg::B_PG_FAULT) |
                    (32'h1 << mexc_pkg::B_PROT) |
                    (32'h1 << mexc_pkg::B_DATA)));

  // Responses
  wire reply_addr = (ev_inv_mem_i & (acc_read_i | acc_translated_i)) |
                    (inv_io & ~ev_io_write_i & ~diag_mode_i);
  wire reply_other = ~diag_mode_i & (
                    (ev_ue_i & (acc_read_i | acc_translated_i)) |
                    (ev_reload_ok_i & reload_rpt_en_i) |
                    virt_ev | ev_dup_tlb_i);
  wire nxt_reply  = reply_addr | reply_other;
  // A held ECC address also blocks further ECC machine checks
  wire nxt_mchk   = ~diag_mode_i & (ev_dup_tlb_i |
                    (~hold_ff & (ev_ue_i | (ev_ce_i & ce_int_en_i))));
  wire pgm_ev     = (ev_inv_mem_i & ~acc_read_i & ~acc_translated_i) |
                    (inv_io & ev_io_write_i) | ev_rom_wr_i;

  // Holder load: virtual errors win over real ones in the same cycle
  wire load_virt  = virt_cpu & ~lock_ff;
  wire load_real  = real_ev & ~lock_ff & ~hold_ff & ~load_virt;
  wire nxt_lock   = load_virt | (lock_ff & ~holder_access_i);
  wire nxt_hold   = (load_real & (ev_ue_i | ce_report)) |
                    (hold_ff & ~diag_reg_rd_i);
  wire ecc_latch  = ~hold_ff & (ev_ue_i | ce_report);

  always_comb begin
    set_bits = 32'h0;
    set_bits[mexc_pkg::B_SEGPROT]  = ev_segprot_i & src_cpu_i;
    set_bits[mexc_pkg::B_INV_MEM]  = ev_inv_mem_i;
    set_bits[mexc_pkg::B_INV_IO]   = inv_io;
    set_bits[mexc_pkg::B_UE]       = ev_ue_i;
    set_bits[mexc_pkg::B_CE]       = ev_ce_i & ~status_ff[mexc_pkg::B_UE] &
                                     ~ev_ue_i;
    set_bits[mexc_pkg::B_RELOAD]   = ev_reload_ok_i & reload_rpt_en_i;
    set_bits[mexc_pkg::B_ROM_WR]   = ev_rom_wr_i;
    set_bits[mexc_pkg::B_PT_SPEC]  = long_stop & src_cpu_i;
    set_bits[mexc_pkg::B_EXT_DEV]  = virt_ev & src_io_channel_controller_i;
    set_bits[mexc_pkg::B_MULTI]    = virt_cpu & lock_ff & virt_mask;
    set_bits[mexc_pkg::B_PG_FAULT] = pg_fault & src_cpu_i;
    set_bits[mexc_pkg::B_TLB_SPEC] = ev_dup_tlb_i;
    set_bits[mexc_pkg::B_PROT]     = ev_prot_i & src_cpu_i;
    set_bits[mexc_pkg::B_DATA]     = ev_data_i & src_cpu_i;
  end

  // Set wins over a software write in the same cycle
  wire [31:0] base_status = status_wr_i ? status_wdata_i : status_ff;
  wire        acc_upd     = virt_cpu;
  wire        acc_bit     = acc_upd ? acc_load_i :
                            base_status[mexc_pkg::B_ACC_LOAD];

  always_comb begin
    nxt_status = (base_status | set_bits) & mexc_pkg::STATUS_MASK;
    nxt_status[mexc_pkg::B_ACC_LOAD] = acc_bit;
  end

  wire [31:0] nxt_addr = load_virt ? fault_addr_i :
                         mexc_pkg::real_addr(fault_addr_i);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      status_ff <= mexc_pkg::STATUS_RESET;
      rdata_ff  <= 32'h0000_0000;
      reply_ff  <= 1'b0;
      mchk_ff   <= 1'b0;
      pgm_n_ff  <= 1'b1;
      load_ff   <= 1'b0;
      addr_ff   <= 32'h0000_0000;
      lock_ff   <= 1'b0;
      hold_ff   <= 1'b0;
      latch_ff  <= 1'b0;
      rpn_ff    <= 22'h00_0000;
    end else begin
      status_ff <= nxt_status;
      if (status_rd_i)
        rdata_ff <= status_ff & mexc_pkg::STATUS_MASK;
      reply_ff  <= nxt_reply;
      mchk_ff   <= nxt_mchk;
      pgm_n_ff  <= ~(pgm_ev | (~pgm_n_ff & ~status_rd_i));
      load_ff   <= load_virt | load_real;
      if (load_virt | load_real)
        addr_ff <= nxt_addr;
      lock_ff   <= nxt_lock;
      hold_ff   <= nxt_hold;
      latch_ff  <= ecc_latch;
      if (ev_dup_tlb_i)
        rpn_ff <= rpn_a_i | rpn_b_i;
    end
  end

  assign status_rdata_o   = rdata_ff;
  assign exc_reply_o      = reply_ff;
  assign machine_check_o  = mchk_ff;
  assign pgm_check_n_o    = pgm_n_ff;
  assign holder_load_o    = load_ff;
  assign holder_addr_o    = addr_ff;
  assign holder_locked_o  = lock_ff;
  assign ecc_hold_o       = hold_ff;
  assign ecc_bits_latch_o = latch_ff;
  assign store_rpn_o      = rpn_ff;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_ue_seen;
    ev_ue_i && !diag_mode_i && !hold_ff;
  endsequence

  a_inv_mem_reply: assert property (
    ev_inv_mem_i && acc_read_i |=> exc_reply_o)
    else $error("invalid memory read without reply");
  a_inv_io_flag: assert property (
    ev_io_rd_wronly_i |=> status_ff[mexc_pkg::B_INV_IO])
    else $error("invalid I/O flag not set");
  a_io_wr_pgm: assert property (
    ev_io_reserved_i && ev_io_write_i |=> !pgm_check_n_o)
    else $error("I/O write error without program check");
  a_ue_mchk: assert property (
    s_ue_seen |=> machine_check_o && status_ff[mexc_pkg::B_UE])
    else $error("uncorrectable error not reported");
  a_hold_blocks: assert property (
    hold_ff && !diag_reg_rd_i && !virt_cpu |=> !holder_load_o)
    else $error("held ECC address overwritten");
  a_ce_blocked: assert property (
    status_ff[mexc_pkg::B_UE] && !status_wr_i
    |=> $stable(status_ff[mexc_pkg::B_CE]))
    else $error("correctable flag set over uncorrectable");
  a_diag_no_mchk: assert property (
    diag_mode_i |=> !machine_check_o)
    else $error("machine check in diagnostic mode");
  a_virt_lock: assert property (
    virt_cpu && !lock_ff |=> holder_locked_o && holder_load_o
    && holder_addr_o == $past(fault_addr_i))
    else $error("virtual error did not load and lock");
  a_rom_pgm: assert property (
    ev_rom_wr_i |=> !pgm_check_n_o ##0 status_ff[mexc_pkg::B_ROM_WR])
    else $error("ROM write not reported");
  a_pgm_release: assert property (
    status_rd_i && !pgm_ev |=> pgm_check_n_o)
    else $error("program check not released by read");
  a_dup_rpn: assert property (
    ev_dup_tlb_i |=> store_rpn_o == ($past(rpn_a_i) | $past(rpn_b_i)))
    else $error("duplicate match page number wrong");
  a_multi_flag: assert property (
    virt_cpu && lock_ff && virt_mask |=> status_ff[mexc_pkg::B_MULTI])
    else $error("multiple exception not flagged");
endmodule : mem_exc_report

// >>> channel_event_model.sv
// Purpose: Far-side model issuing processor channel event strobes
// Assumes: The bench holds go_i high for one cycle per event
// Notes:   Address is inverted while idle so a stale value never matches
`timescale 1ns/1ps
module channel_event_model (
  input  wire logic        go_i,
  input  wire logic [3:0]  code_i,
  input  wire logic [31:0] addr_i,
  output logic      [13:0] strobe_o,
  output logic      [31:0] fault_addr_o
);
  // One event at a time, as only one channel transfer is faulted per cycle
  assign strobe_o     = go_i ? (14'h0001 << code_i) : 14'h0000;
  assign fault_addr_o = go_i ? addr_i : ~addr_i;
endmodule : channel_event_model

// >>> memory_exception_reporting_bench.sv
// Purpose: Self-checking bench for the memory exception reporting block
// Assumes: Responses land exactly one cycle after the event edge
// Notes:   Results are checked on the falling edge, once settled
`timescale 1ns/1ps
module memory_exception_reporting_bench;
  typedef struct packed {
    logic [1:0]  kind;
    logic [6:0]  resp;
    logic [31:0] word;
  } note_s;
  logic        mclk_i, rst_i, diag, ce_en, rl_en, ls_en, go, probe, probe_q;
  logic        s_start, s_cmp, s_match, s_rd, s_wr, h_acc, d_rd, ecc_held;
  logic        latch, reply, mc, pgm_n, hload, locked, hold;
  logic [3:0]  code;
  logic [6:0]  attr;
  logic [13:0] ev;
  logic [21:0] ra, rb, srpn;
  logic [31:0] addr, faddr, rdata, haddr, wd;
  note_s       q[$];
  int          num_errors, checks;

  channel_event_model channel_event_model_i (.go_i(go), .code_i(code),
    .addr_i(addr), .strobe_o(ev), .fault_addr_o(faddr));

  mem_exc_report mem_exc_report_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .diag_mode_i(diag),
    .ce_int_en_i(ce_en), .reload_rpt_en_i(rl_en),
    .long_search_en_i(ls_en), .fault_addr_i(faddr),
    .acc_read_i(attr[5]), .acc_translated_i(attr[4]),
    .acc_load_i(attr[3]), .src_cpu_i(attr[2]),
    .src_cpu_ldst_i(attr[1]), .src_io_channel_controller_i(attr[0]),
    .ev_inv_mem_i(ev[0]), .ev_io_reserved_i(ev[1]),
    .ev_io_rd_wronly_i(ev[2]), .ev_io_write_i(attr[6]),
    .ev_ue_i(ev[3]), .ev_ce_i(ev[4]), .ev_reload_ok_i(ev[5]),
    .ev_rom_wr_i(ev[6]), .ev_no_xlate_i(ev[7]),
    .ev_reset_in_reload_i(ev[8]), .ev_reload_abort_i(ev[9]),
    .ev_dup_tlb_i(ev[10]), .ev_segprot_i(ev[11]), .ev_prot_i(ev[12]),
    .ev_data_i(ev[13]), .search_start_i(s_start),
    .search_compare_i(s_cmp), .search_match_i(s_match),
    .rpn_a_i(ra), .rpn_b_i(rb), .status_rd_i(s_rd), .status_wr_i(s_wr),
    .status_wdata_i(wd), .holder_access_i(h_acc),
    .diag_reg_rd_i(d_rd), .status_rdata_o(rdata), .exc_reply_o(reply),
    .machine_check_o(mc), .pgm_check_n_o(pgm_n), .holder_load_o(hload),
    .holder_addr_o(haddr), .holder_locked_o(locked), .ecc_hold_o(hold),
    .ecc_bits_latch_o(latch), .store_rpn_o(srpn));

  function automatic logic [31:0] fb(input int unsigned p);
    return 32'h0000_0001 << p;
  endfunction : fb

  task automatic cmp_word(input string n, input logic [31:0] e,
                          input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_word

  task automatic cmp_resp(input logic [6:0] e);
    checks++;
    if ({latch, reply, mc, pgm_n, hload, locked, hold} !== e) begin
      num_errors++;
      $display("CHECK FAILED response expected %h seen %h", e,
               {latch, reply, mc, pgm_n, hload, locked, hold});
    end
  endtask : cmp_resp

  // Attr is {io_write, read, translated, load, cpu, cpu_ldst, io_channel_controller}
  // Resp is {ecc_latch, reply, machine_check, pgm_n, load, locked, ecc_hold}
  task automatic fire(input logic [3:0] c, input logic [6:0] at,
                      input logic [5:0] e, input logic virt);
    logic [31:0] a;
    logic [21:0] x, y;
    logic        lat;
    a = $urandom();
    x = 22'($urandom());
    y = 22'($urandom());
    @(posedge mclk_i);
    // Check bits latch on a reported ECC event only when none are held
    lat = (c == 4'h3 || (c == 4'h4 && (ce_en || diag))) && !ecc_held;
    ecc_held = ecc_held | lat;
    go <= 1'b1;
    code <= c;
    attr <= at;
    addr <= a;
    ra <= x;
    rb <= y;
    probe <= 1'b1;
    if (c == 4'ha) q.push_back({2'h2, 1'b0, e, {10'h000, x | y}});
    else q.push_back({2'h0, lat, e, virt ? a : a & mexc_pkg::REAL_MASK});
    @(posedge mclk_i);
    go <= 1'b0;
    probe <= 1'b0;
  endtask : fire

  task automatic rd(input string n, input logic [31:0] e);
    @(posedge mclk_i);
    s_rd <= 1'b1;
    probe <= 1'b1;
    q.push_back({2'h1, 7'h00, e});
    @(posedge mclk_i);
    s_rd <= 1'b0;
    probe <= 1'b0;
    $display("test %s done", n);
  endtask : rd

  // 0: status write of wd, 1: holder access, 2: diagnostic register read
  task automatic poke(input int w);
    @(posedge mclk_i);
    {s_wr, h_acc, d_rd} <= 3'h4 >> w;
    if (w == 2) ecc_held = 1'b0;
    @(posedge mclk_i);
    {s_wr, h_acc, d_rd} <= 3'h0;
  endtask : poke

  task automatic results();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  always @(posedge mclk_i) probe_q <= probe;

  always @(negedge mclk_i) begin : watch
    note_s n;
    if (probe_q === 1'b1) begin
      n = q.pop_front();
      if (n.kind == 2'h1) cmp_word("status_rdata", n.word, rdata);
      else cmp_resp(n.resp);
      if (n.kind == 2'h0 && n.resp[2])
        cmp_word("holder_addr", n.word, haddr);
      if (n.kind == 2'h2)
        cmp_word("store_rpn", n.word, {10'h000, srpn});
    end
  end

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    $display("CHECK FAILED run_length expected end seen hang");
    results();
  end

  initial begin
    void'($urandom(43));
    {rst_i, diag, ce_en, rl_en, ls_en, go, probe} = 7'h40;
    {s_start, s_cmp, s_match, s_rd, s_wr, h_acc, d_rd, ecc_held} = 8'h00;
    {code, attr, addr, ra, rb, wd} = 119'h0;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd("reset", 32'h0000_0000);
    fire(4'h0, 7'h34, 6'h2c, 1'b0);
    fire(4'h0, 7'h04, 6'h04, 1'b0);
    rd("inv_mem", fb(mexc_pkg::B_INV_MEM));
    poke(0);
    diag <= 1'b1;
    fire(4'h1, 7'h24, 6'h0c, 1'b0);
    diag <= 1'b0;
    fire(4'h2, 7'h24, 6'h2c, 1'b0);
    fire(4'h1, 7'h44, 6'h04, 1'b0);
    rd("inv_io", fb(mexc_pkg::B_INV_IO));
    poke(0);
    ce_en <= 1'b1;
    fire(4'h3, 7'h34, 6'h3d, 1'b0);
    fire(4'h4, 7'h24, 6'h09, 1'b0);
    fire(4'h0, 7'h34, 6'h29, 1'b0);
    rd("ue", fb(mexc_pkg::B_UE) | fb(mexc_pkg::B_INV_MEM));
    poke(2);
    poke(0);
    fire(4'h4, 7'h24, 6'h1d, 1'b0);
    rd("ce", fb(mexc_pkg::B_CE));
    poke(2);
    poke(0);
    ce_en <= 1'b0;
    fire(4'hc, 7'h06, 6'h2e, 1'b1);
    fire(4'hd, 7'h0e, 6'h2a, 1'b1);
    rd("virt", fb(mexc_pkg::B_PROT) | fb(mexc_pkg::B_DATA) |
       fb(mexc_pkg::B_MULTI) | fb(mexc_pkg::B_ACC_LOAD));
    poke(1);
    poke(0);
    fire(4'h7, 7'h01, 6'h28, 1'b0);
    for (int c = 7; c <= 9; c++) fire(4'(c), 7'h04, 6'h28, 1'b0);
    fire(4'hb, 7'h04, 6'h28, 1'b0);
    rd("fault", fb(mexc_pkg::B_EXT_DEV) | fb(mexc_pkg::B_PG_FAULT) |
       fb(mexc_pkg::B_SEGPROT));
    poke(0);
    fire(4'ha, 7'h06, 6'h3e, 1'b0);
    poke(1);
    rl_en <= 1'b1;
    fire(4'h5, 7'h04, 6'h28, 1'b0);
    diag <= 1'b1;
    fire(4'h5, 7'h04, 6'h08, 1'b0);
    {diag, rl_en} <= 2'h0;
    fire(4'h6, 7'h04, 6'h04, 1'b0);
    rd("dup_rom", fb(mexc_pkg::B_TLB_SPEC) | fb(mexc_pkg::B_RELOAD) |
       fb(mexc_pkg::B_ROM_WR));
    poke(0);
    // Reserved positions must not keep what software writes
    wd <= $urandom();
    poke(0);
    rd("wr_mask", wd & mexc_pkg::STATUS_MASK);
    wd <= 32'h0000_0000;
    poke(0);
    // One compare short of the limit must stay silent
    @(posedge mclk_i);
    {ls_en, s_start} <= 2'h3;
    @(posedge mclk_i);
    {s_start, s_cmp} <= 2'h1;
    repeat (126) @(posedge mclk_i);
    s_cmp <= 1'b0;
    rd("search_126", 32'h0000_0000);
    // A matching 127th compare ends the chain without a report
    @(posedge mclk_i);
    {s_cmp, s_match} <= 2'h3;
    @(posedge mclk_i);
    {s_cmp, s_match} <= 2'h0;
    repeat (3) @(posedge mclk_i);
    rd("search_match", 32'h0000_0000);
    @(posedge mclk_i);
    s_start <= 1'b1;
    @(posedge mclk_i);
    {s_start, s_cmp} <= 2'h1;
    repeat (127) @(posedge mclk_i);
    s_cmp <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rd("search_127", fb(mexc_pkg::B_PT_SPEC));
    repeat (3) @(posedge mclk_i);
    results();
  end
endmodule : memory_exception_reporting_bench
